// ### hw/ubg_pkg.sv
// Constants and carrier types for the serial port enable/baud/scratch block.
// Assumes a single 250 MHz system clock and a plain strobe register port.
package ubg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SCRATCH     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SPEED_CFG   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PREDIV_CFG  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CTRL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_GEN_STATE   = 8'h24;

  // Values after reset
  localparam logic [3:0] RST_IRQ_ENABLE = 4'h0;
  localparam logic [7:0] RST_DIV_LOW    = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH   = 8'h00;
  localparam logic [7:0] RST_SCRATCH    = 8'h00;
  localparam logic [7:0] RST_SPEED_CFG  = 8'h00;
  localparam logic [1:0] RST_PREDIV_CFG = 2'h0;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [1:0] RST_EVT        = 2'h0;
  localparam logic [3:0]  RST_PRE_ACC   = 4'h0;
  localparam logic [15:0] RST_DIV_CNT   = 16'h0000;
  localparam logic [3:0]  RST_OS_CNT    = 4'h0;

  // Field positions
  localparam int SPEED_HS_HI_BIT = 7;
  localparam int SPEED_HS_LO_BIT = 6;
  localparam int MODEM_IRQ_OE_BIT = 3;
  localparam int EVT_PORT_IRQ_BIT = 0;
  localparam int EVT_RELOAD_BIT   = 1;
  localparam int GEN_HS_BIT       = 16;

  localparam logic [1:0] SPEED_HS_CODE = 2'b11;

  // Pre-divider selections: ratio = modulus / step
  localparam logic [1:0] PREDIV_SEL_13    = 2'h0;
  localparam logic [1:0] PREDIV_SEL_1P625 = 2'h1;
  localparam logic [3:0] PREDIV_13_STEP    = 4'h1;
  localparam logic [3:0] PREDIV_13_MOD     = 4'hD;
  localparam logic [3:0] PREDIV_1P625_STEP = 4'h8;
  localparam logic [3:0] PREDIV_1P625_MOD  = 4'hD;
  localparam logic [3:0] PREDIV_1_STEP     = 4'h1;
  localparam logic [3:0] PREDIV_1_MOD      = 4'h1;

  // Sixteen sampling ticks per bit
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;

  // Interrupt sources, in enable-register bit order
  typedef struct packed {
    logic handshake;
    logic line_status;
    logic tx_empty;
    logic rx_ready;
  } ubg_irq_src_t;

endpackage

// ### hw/ubg_uart_baud_irq.sv
// Serial port interrupt enables, baud generator, scratch and modem control bit.
// Assumes a 250 MHz clk_sys_in, a 24 MHz reference on a pin, and interrupt
// source levels from neighbouring logic on the same clock.
//
// What this block does
// - Enable register reads zero in bits 7 to 4.
// - Enable bit 3 passes the handshake status change interrupt.
// - Enable bit 2 passes the receive line status interrupt.
// - Enable bit 1 passes the transmit buffer empty interrupt.
// - Enable bit 0 passes the receive data ready interrupt.
// - All four enables clear means no interrupt; enables act independently.
// - Two readable 8-bit registers hold the baud divisor.
// - Normal speed pre-divides 24 MHz to about 1.8461 MHz, then by divisor.
// - Divisor accepts any value from one to 65535.
// - Generator output is sixteen times bit rate, shared by transmit and receive.
// - High-speed mode skips the pre-divider, same divisor.
// - High-speed mode chosen by bits 7 and 6 of the speed configuration.
// - High-speed with divisor one gives 1.5 Mbit/s.
// - Configuration picks pre-divide ratio 13, 1.625 or 1.0.
// - Scratch register stores and returns the last written byte.
// - Port interrupt reaches host only while modem control bit 3 is set.
`timescale 1ns/1ps

module ubg_uart_baud_irq
  import ubg_pkg::*;
(
  input  logic              clk_sys_in,
  input  logic              nrst_in,
  input  logic [ADDR_W-1:0] bus_addr_in,
  input  logic [DATA_W-1:0] bus_wdata_in,
  input  logic              bus_wr_in,
  input  logic              bus_rd_in,
  output logic [DATA_W-1:0] bus_rdata_out,
  input  logic              ref_clk_in,
  input  ubg_irq_src_t      irq_src_in,
  output logic              port_irq_out,
  output logic              baud16_tick_out,
  output logic              bit_tick_out,
  output logic              irq_out
);

  function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction

  // One compare per register keeps read and write decode from drifting apart
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    return (a == off);
  endfunction

  // Reset release
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q1 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
    end
  end

  // Second stage only reads the first, so release is clean to the clock
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_n <= 1'b0;
    end else begin
      rst_n <= rst_q1;
    end
  end

  // Registers
  logic [3:0]  irq_enable;
  logic [7:0]  divisor_low;
  logic [7:0]  divisor_high;
  logic [7:0]  scratch_reg;
  logic [7:0]  speed_config_reg;
  logic [1:0]  predivider_config_reg;
  logic [7:0]  modem_control_reg;
  logic [1:0]  evt_status;
  logic [1:0]  evt_mask;

  // Register selects
  wire sel_ier    = addr_hit(bus_addr_in, OFF_IRQ_ENABLE);
  wire sel_dlo    = addr_hit(bus_addr_in, OFF_DIV_LOW);
  wire sel_dhi    = addr_hit(bus_addr_in, OFF_DIV_HIGH);
  wire sel_scr    = addr_hit(bus_addr_in, OFF_SCRATCH);
  wire sel_speed  = addr_hit(bus_addr_in, OFF_SPEED_CFG);
  wire sel_prediv = addr_hit(bus_addr_in, OFF_PREDIV_CFG);
  wire sel_modem  = addr_hit(bus_addr_in, OFF_MODEM_CTRL);
  wire sel_status = addr_hit(bus_addr_in, OFF_EVT_STATUS);
  wire sel_mask   = addr_hit(bus_addr_in, OFF_EVT_MASK);
  wire sel_gen    = addr_hit(bus_addr_in, OFF_GEN_STATE);

  // Write decode
  wire wr_ier    = bus_wr_in && sel_ier;
  wire wr_dlo    = bus_wr_in && sel_dlo;
  wire wr_dhi    = bus_wr_in && sel_dhi;
  wire wr_scr    = bus_wr_in && sel_scr;
  wire wr_speed  = bus_wr_in && sel_speed;
  wire wr_prediv = bus_wr_in && sel_prediv;
  wire wr_modem  = bus_wr_in && sel_modem;
  wire wr_status = bus_wr_in && sel_status;
  wire wr_mask   = bus_wr_in && sel_mask;

  // Next register values: hold unless written; upper enable bits not stored
  wire [3:0] next_irq_enable   = wr_ier ? bus_wdata_in[3:0] : irq_enable;
  wire [7:0] next_divisor_low  = wr_dlo ? bus_wdata_in[7:0] : divisor_low;
  wire [7:0] next_divisor_high = wr_dhi ? bus_wdata_in[7:0] : divisor_high;
  wire [7:0] next_scratch      = wr_scr ? bus_wdata_in[7:0] : scratch_reg;
  wire [7:0] next_speed_cfg    = wr_speed ? bus_wdata_in[7:0] : speed_config_reg;
  wire [1:0] next_prediv_cfg   = wr_prediv ? bus_wdata_in[1:0] : predivider_config_reg;
  wire [7:0] next_modem_ctrl   = wr_modem ? bus_wdata_in[7:0] : modem_control_reg;
  wire [1:0] next_evt_mask     = wr_mask ? bus_wdata_in[1:0] : evt_mask;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= RST_IRQ_ENABLE;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      divisor_low <= RST_DIV_LOW;
    end else begin
      divisor_low <= next_divisor_low;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      divisor_high <= RST_DIV_HIGH;
    end else begin
      divisor_high <= next_divisor_high;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= RST_SCRATCH;
    end else begin
      scratch_reg <= next_scratch;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      speed_config_reg <= RST_SPEED_CFG;
    end else begin
      speed_config_reg <= next_speed_cfg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      predivider_config_reg <= RST_PREDIV_CFG;
    end else begin
      predivider_config_reg <= next_prediv_cfg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      modem_control_reg <= RST_MODEM_CTRL;
    end else begin
      modem_control_reg <= next_modem_ctrl;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask <= RST_EVT;
    end else begin
      evt_mask <= next_evt_mask;
    end
  end

  // Reference clock pin: three stages, a change counts once stages two
  // and three agree, so a single metastable sample cannot fake an edge.
  logic ref_s1;
  logic ref_s2;
  logic ref_s3;
  logic ref_level;

  wire ref_agree = (ref_s2 == ref_s3);
  wire ref_rise  = ref_agree && ref_s3 && !ref_level;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1    <= 1'b0;
      ref_s2    <= 1'b0;
      ref_s3    <= 1'b0;
      ref_level <= 1'b0;
    end else begin
      ref_s1 <= ref_clk_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      if (ref_agree) begin
        ref_level <= ref_s3;
      end
    end
  end

  // Pre-divider: fractional accumulator, ratio modulus/step.
  // The 1.625 ratio yields ticks spaced 1 or 2 reference periods; the mean
  // rate is exact, at the cost of a little jitter on the 16x clock.
  wire high_speed = ({speed_config_reg[SPEED_HS_HI_BIT],
                      speed_config_reg[SPEED_HS_LO_BIT]} == SPEED_HS_CODE);

  wire sel_13    = (predivider_config_reg == PREDIV_SEL_13);
  wire sel_1p625 = (predivider_config_reg == PREDIV_SEL_1P625);

  // High speed bypasses the selected ratio entirely
  wire [3:0] pre_step = high_speed ? PREDIV_1_STEP :
                        sel_13     ? PREDIV_13_STEP :
                        sel_1p625  ? PREDIV_1P625_STEP :
                                     PREDIV_1_STEP;
  wire [3:0] pre_mod  = high_speed ? PREDIV_1_MOD :
                        sel_13     ? PREDIV_13_MOD :
                        sel_1p625  ? PREDIV_1P625_MOD :
                                     PREDIV_1_MOD;

  logic [3:0] pre_acc;

  wire [4:0] pre_sum  = {1'b0, pre_acc} + {1'b0, pre_step};
  wire       pre_wrap = (pre_sum >= {1'b0, pre_mod});
  wire       pre_tick = ref_rise && pre_wrap;
  wire [4:0] pre_left = pre_sum - {1'b0, pre_mod};

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_acc <= RST_PRE_ACC;
    end else if (ref_rise) begin
      pre_acc <= pre_wrap ? pre_left[3:0] : pre_sum[3:0];
    end
  end

  // Divisor counter: counts pre-divided ticks down and reloads from the
  // programmed bytes only at wrap, so a half-written divisor never
  // shortens the period in flight. Zero halts the generator.
  wire [15:0] divisor_prog = {divisor_high, divisor_low};

  logic [15:0] div_cnt;
  logic [15:0] div_active;
  logic        next_baud16;
  logic        reload_changed;

  wire div_expire = pre_tick && (div_cnt == 16'h0001);
  wire div_reload = pre_tick && (div_cnt <= 16'h0001);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt    <= RST_DIV_CNT;
      div_active <= RST_DIV_CNT;
    end else if (div_reload) begin
      div_cnt    <= divisor_prog;
      div_active <= divisor_prog;
    end else if (pre_tick) begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  // One tick per divisor periods; divisor one at 24 MHz gives 1.5 Mbit/s
  assign next_baud16    = div_expire;
  assign reload_changed = div_reload && (divisor_prog != div_active);

  // Bit-rate enable from sixteen sampling ticks
  logic [3:0] os_cnt;

  // The bit counter is free running: framing logic aligns to start bits itself
  wire next_bit_tick = next_baud16 && (os_cnt == OVERSAMPLE_LAST);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      os_cnt <= RST_OS_CNT;
    end else if (next_baud16) begin
      os_cnt <= os_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      baud16_tick_out <= 1'b0;
      bit_tick_out    <= 1'b0;
    end else begin
      baud16_tick_out <= next_baud16;
      bit_tick_out    <= next_bit_tick;
    end
  end

  // Port interrupt gating
  wire [3:0] src_vec = irq_src_in;
  wire [3:0] src_on  = src_vec & irq_enable;
  wire       any_src = |src_on;
  wire       next_port_irq = any_src && modem_control_reg[MODEM_IRQ_OE_BIT];

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      port_irq_out <= 1'b0;
    end else begin
      port_irq_out <= next_port_irq;
    end
  end

  // Block events: port interrupt rising, divisor change applied at reload.
  // Set beats a same-cycle write-one clear so no event is dropped.
  wire [1:0] evt_set;
  wire [1:0] evt_clr = wr_status ? bus_wdata_in[1:0] : 2'b00;

  assign evt_set[EVT_PORT_IRQ_BIT] = next_port_irq && !port_irq_out;
  assign evt_set[EVT_RELOAD_BIT]   = reload_changed;

  wire [1:0] next_evt_status = (evt_status & ~evt_clr) | evt_set;

  wire next_irq = |(next_evt_status & evt_mask);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= RST_EVT;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  // Generator state: active divisor and speed mode
  wire [DATA_W-1:0] gen_state;

  assign gen_state = {15'h0000, high_speed, div_active};

  // Read values per register, zero-extended to the bus width
  wire [DATA_W-1:0] rd_ier    = zext8({4'h0, irq_enable});
  wire [DATA_W-1:0] rd_dlo    = zext8(divisor_low);
  wire [DATA_W-1:0] rd_dhi    = zext8(divisor_high);
  wire [DATA_W-1:0] rd_scr    = zext8(scratch_reg);
  wire [DATA_W-1:0] rd_speed  = zext8(speed_config_reg);
  wire [DATA_W-1:0] rd_prediv = zext8({6'h00, predivider_config_reg});
  wire [DATA_W-1:0] rd_modem  = zext8(modem_control_reg);
  wire [DATA_W-1:0] rd_status = zext8({6'h00, evt_status});
  wire [DATA_W-1:0] rd_mask   = zext8({6'h00, evt_mask});

  // Unmapped addresses read as zero rather than aliasing a register
  wire [DATA_W-1:0] rd_mux =
    sel_ier    ? rd_ier :
    sel_dlo    ? rd_dlo :
    sel_dhi    ? rd_dhi :
    sel_scr    ? rd_scr :
    sel_speed  ? rd_speed :
    sel_prediv ? rd_prediv :
    sel_modem  ? rd_modem :
    sel_status ? rd_status :
    sel_mask   ? rd_mask :
    sel_gen    ? gen_state :
                 32'h0000_0000;

  // Read data stands only in the cycle after the strobe; zero otherwise,
  // so a late sample by the host cannot pick up a stale value.
  wire [DATA_W-1:0] next_rdata = bus_rd_in ? rd_mux : 32'h0000_0000;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_out <= 32'h0000_0000;
    end else begin
      bus_rdata_out <= next_rdata;
    end
  end

endmodule

// ### sim/ubg_ref_osc.sv
// Free-running 24 MHz reference oscillator driving the baud generator pin.
// Assumes nothing of the block; phase is unrelated to the system clock.
`timescale 1ns/1ps

module ubg_ref_osc #(
  parameter real HALF_NS = 20.8333
) (
  output logic ref_out
);
  // An oscillator runs free, so it keeps toggling through reset too
  initial begin
    ref_out = 1'b0;
    #3.1;
    forever #(HALF_NS) ref_out = ~ref_out;
  end
endmodule

// ### sim/ubg_uart_baud_irq_chk.sv
// Port-level checker for the enable/baud/scratch block, attached by bind.
// Assumes the register offsets of the package and one clock domain.
`timescale 1ns/1ps

module ubg_uart_baud_irq_chk
  import ubg_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              nrst_in,
  input wire logic [ADDR_W-1:0] bus_addr_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic              bus_wr_in,
  input wire logic              bus_rd_in,
  input wire logic [DATA_W-1:0] bus_rdata_out,
  input wire ubg_irq_src_t      irq_src_in,
  input wire logic              port_irq_out,
  input wire logic              baud16_tick_out,
  input wire logic              bit_tick_out
);
  logic [3:0] en;
  logic       oe;
  logic [3:0] nticks;
  wire        wr_en = bus_wr_in && (bus_addr_in == OFF_IRQ_ENABLE);
  wire        wr_mc = bus_wr_in && (bus_addr_in == OFF_MODEM_CTRL);
  wire        rd_en = bus_rd_in && (bus_addr_in == OFF_IRQ_ENABLE);
  wire        gate  = (|(irq_src_in & en)) & oe;

  // Shadow copies of the enable bits and of the sampling tick count, since the checker cannot see inside
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en     <= 4'h0;
      oe     <= 1'b0;
      nticks <= 4'h0;
    end else begin
      if (wr_en) en <= bus_wdata_in[3:0];
      if (wr_mc) oe <= bus_wdata_in[MODEM_IRQ_OE_BIT];
      if (baud16_tick_out) nticks <= nticks + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_rdata_idle: assert property (!$past(bus_rd_in) |-> bus_rdata_out == '0)
    else $error("read data not zero outside read answer");
  a_ien_read: assert property ($past(rd_en) |->
    bus_rdata_out == {{(DATA_W-4){1'b0}}, $past(en)})
    else $error("enable register read wrong");
  a_irq_gate: assert property (port_irq_out == $past(gate))
    else $error("port interrupt does not follow enabled sources");
  a_irq_none: assert property (en == 4'h0 |=> !port_irq_out)
    else $error("port interrupt with all enables clear");
  a_irq_oe_off: assert property (!oe |=> !port_irq_out)
    else $error("port interrupt while output enable clear");
  a_bit_pair: assert property (bit_tick_out |-> baud16_tick_out)
    else $error("bit tick without sampling tick");
  a_bit_sixteen: assert property (baud16_tick_out |->
    bit_tick_out == (nticks == 4'hF))
    else $error("bit tick not on sixteenth sampling tick");
  a_tick_gap: assert property (baud16_tick_out |=> !baud16_tick_out [*8])
    else $error("sampling ticks faster than reference");
endmodule

bind ubg_uart_baud_irq ubg_uart_baud_irq_chk i_chk (
  .clk_sys_in, .nrst_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in,
  .bus_rdata_out, .irq_src_in, .port_irq_out, .baud16_tick_out, .bit_tick_out
);

// ### sim/ubg_uart_baud_irq_tb.sv
// Self-checking bench: register port, interrupt gating, baud tick rates.
// Assumes the package offsets and a free-running 24 MHz reference model.
`timescale 1ns/1ps

module ubg_uart_baud_irq_tb;
  import ubg_pkg::*;
  localparam real       REF_NS = 41.6667;
  localparam logic [7:0] SP[5] = '{8'h00, 8'hC0, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] PD[5] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'h02};
  localparam logic [7:0] DV[5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03};
  localparam int         EX[5] = '{650, 650, 50, 400, 217};
  logic              clk, rst_n, wr, rd, rd_q, ref_clk, port_irq, b16, bitt, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [7:0]        lfsr;
  ubg_irq_src_t      src;
  logic [31:0]       exp_q[$];
  int                failures, check_count, n16, nbit, n0, b0;

  ubg_ref_osc i_ubg_ref_osc (.ref_out(ref_clk));
  ubg_uart_baud_irq i_ubg_uart_baud_irq (
    .clk_sys_in(clk), .nrst_in(rst_n), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .ref_clk_in(ref_clk),
    .irq_src_in(src), .port_irq_out(port_irq), .baud16_tick_out(b16),
    .bit_tick_out(bitt), .irq_out(irq));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic near(input int seen, input int exp);
    check(((seen - exp <= 2) && (exp - seen <= 2)) ? exp : seen, exp);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic irq_chk(input logic [3:0] s, input logic e);
    @(posedge clk);
    src <= s;
    repeat (2) @(posedge clk);
    #1 check(32'(port_irq), 32'(e));
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts come from the design's pulses; reads are scored a cycle later
  always @(posedge clk) begin
    rd_q <= rd;
    if (b16) n16++;
    if (bitt) nbit++;
  end
  always @(negedge clk) if (rd_q) check(rdata, exp_q.pop_front());

  initial begin
    #300_000;
    failures++;
    summarize();
  end

  initial begin
    {rst_n, wr, rd, addr, wdata, src} = '0;
    lfsr = 8'h27;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) bus_rd(8'(4 * i), (i == 1) ? 32'h1 : 32'h0);
    bus_rd(8'h30, 32'h0);
    bus_wr(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    bus_rd(OFF_IRQ_ENABLE, 32'h0000_000F);
    // Random divisor must be undone before the first slow reload picks it up
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      bus_wr(8'(4 * i + 4), {4{lfsr}});
      bus_rd(8'(4 * i + 4), {24'h0, lfsr});
    end
    bus_wr(OFF_DIV_LOW, 32'h1);
    bus_wr(OFF_DIV_HIGH, 32'h0);
    bus_wr(OFF_MODEM_CTRL, 32'h8);
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFF_IRQ_ENABLE, 32'(1 << i));
      irq_chk(~(4'h1 << i), 1'b0);
      irq_chk(4'h1 << i, 1'b1);
    end
    bus_wr(OFF_MODEM_CTRL, 32'h0);
    irq_chk(4'hF, 1'b0);
    bus_wr(OFF_MODEM_CTRL, 32'h8);
    bus_wr(OFF_IRQ_ENABLE, 32'h0);
    irq_chk(4'hF, 1'b0);
    bus_wr(OFF_EVT_MASK, 32'h1);
    irq_chk(4'h0, 1'b0);
    bus_wr(OFF_IRQ_ENABLE, 32'h1);
    irq_chk(4'h1, 1'b1);
    check(32'(irq), 32'h1);
    bus_wr(OFF_EVT_STATUS, 32'h3);
    @(posedge clk);
    src <= 4'h0;
    #1 check(32'(irq), 32'h0);
    for (int k = 0; k < 5; k++) begin
      bus_wr(OFF_SPEED_CFG, 32'(SP[k]));
      bus_wr(OFF_PREDIV_CFG, 32'(PD[k]));
      bus_wr(OFF_DIV_LOW, 32'(DV[k]));
      #(40 * REF_NS);
      n0 = n16;
      b0 = nbit;
      #(650 * REF_NS);
      near(n16 - n0, EX[k]);
      near(nbit - b0, EX[k] / 16);
      bus_rd(OFF_GEN_STATE, {15'h0000, SP[k][7:6] == 2'b11, 8'h00, DV[k]});
    end
    summarize();
  end
endmodule
